// >>> logic/dcawd_ctrl.sv
// Top of the converter clear, alarm and watchdog control block.
// Assumes a 10 MHz clk_sys, synchronous pins apart from the clear input,
// and an Avalon-MM master on the register port.
//
// What this block does
// R1 - Clear input forces output immediately, asynchronously
// R2 - Clear level is pin OR register bit
// R3 - Level 0 zero volts; 1 mid/negative
// R4 - Current output goes lowest during clear
// R5 - Output stays cleared after clear releases
// R6 - Load pulse without clocks restores value
// R7 - New values rejected while clear high
// R8 - Dual mode clear follows voltage range
// R9 - Output enable applies default value
// R10 - Host disables output before range change
// R11 - Reset held until both supplies good
// R12 - Reset defaults; data from select pin
// R13 - Host sends software reset if misordered
// R14 - After brownout host resets device again
// R15 - Fault pin low on any alarm
// R16 - Thermal alarm set 142, clear 124
// R17 - Watchdog and frame faults need enable
// R18 - Host reads status of wired devices
// R19 - Watchdog runs only when enabled
// R20 - Two-bit field selects timeout period
// R21 - Watchdog counts internal oscillator ticks
// R22 - Periods 10, 51, 102, 204 ms
// R23 - Frame to 0x95 restarts watchdog
// R24 - Watchdog flag cleared by reset, disable
// R25 - Counter restarts on frame, enable, change
// R26 - Clear synchronised for register side effects
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dcawd_ctrl #(
    parameter int WD_MS0 = 10,
    parameter int WD_MS1 = 51,
    parameter int WD_MS2 = 102,
    parameter int WD_MS3 = 204
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Avalon-MM slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Host pins
    input  wire logic              output_clear_input,
    input  wire logic              clear_level_select_pin,
    input  wire logic              load_strobe,
    input  wire logic              serial_clock_tick,
    input  wire logic              frame_valid,
    input  wire logic [7:0]        frame_addr,
    input  wire logic              frame_check_error,
    // Supply detectors and analog monitors
    input  wire logic              digital_supply_ok,
    input  wire logic              analog_supply_ok,
    input  wire logic              open_load,
    input  wire logic              headroom_low,
    input  wire logic signed [9:0] die_temp_c,
    // Converter side
    output logic                   clear_forced,
    output logic [15:0]            voltage_code,
    output logic [15:0]            current_code,
    output logic                   output_active,
    // Open-drain fault pin
    output logic                   fault_out,
    output logic                   fault_oe_n
);

    // ***********************************************************
    // Reset release and derived constants
    // ***********************************************************
    localparam logic [23:0] WD_LIM0 = 24'(WD_MS0 * dcawd_pkg::OSC_KHZ);
    localparam logic [23:0] WD_LIM1 = 24'(WD_MS1 * dcawd_pkg::OSC_KHZ);
    localparam logic [23:0] WD_LIM2 = 24'(WD_MS2 * dcawd_pkg::OSC_KHZ);
    localparam logic [23:0] WD_LIM3 = 24'(WD_MS3 * dcawd_pkg::OSC_KHZ);
    localparam logic [13:0] OSC_STEP = 14'(dcawd_pkg::OSC_KHZ);
    localparam logic [13:0] SYS_MOD  = 14'(dcawd_pkg::SYS_KHZ);

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ***********************************************************
    // Clear input capture
    // ***********************************************************
    logic clr_meta;
    logic clr_sync;

    // R1 immediate force flag
    always_ff @(posedge clk_sys or negedge rst_n or
                posedge output_clear_input) begin
        if (!rst_n) begin
            clear_forced <= 1'b0;
        end else if (output_clear_input) begin
            clear_forced <= 1'b1;
        end else begin
            clear_forced <= clr_sync;
        end
    end

    // R26 two-stage synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clr_meta <= 1'b0;
            clr_sync <= 1'b0;
        end else begin
            clr_meta <= output_clear_input;
            clr_sync <= clr_meta;
        end
    end

    // ***********************************************************
    // Registers and state
    // ***********************************************************
    logic        clear_level_select_bit, output_enable_bit, bipolar, dual;
    logic        watchdog_enable_bit, crcen;
    logic [1:0]  tsel;
    logic [15:0] data, pre_clear;
    logic        held, sclk_seen, load_q, por_ok, thermal, crc_flt;
    logic [13:0] osc_acc;
    logic        next_clear_level_select_bit, next_output_enable_bit, next_bipolar, next_dual;
    logic        next_watchdog_enable_bit, next_crcen;
    logic [1:0]  next_tsel;
    logic [15:0] next_data, next_pre_clear;
    logic        next_held, next_sclk_seen, next_thermal, next_crc_flt;
    logic [13:0] next_osc_acc;
    logic        next_wait;
    logic [31:0] next_rdata;
    logic        wd_fault, soft_rst, sys_clear, eff_sel, load_rise;
    logic        wr_ok, osc_tick, fault_any;
    logic [15:0] clr_code;
    logic [31:0] wmask, wval, status;
    logic [23:0] wd_limit;

    // R2 combined select
    assign eff_sel   = clear_level_select_bit | clear_level_select_pin;
    // R3 R8 clear code from voltage settings
    assign clr_code  = (eff_sel ^ bipolar) ? dcawd_pkg::CODE_MID
                                           : dcawd_pkg::CODE_ZERO;
    assign wr_ok     = avs_write && !avs_waitrequest;
    assign wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval      = avs_writedata & wmask;
    assign soft_rst  = wr_ok && (avs_address == dcawd_pkg::ADDR_CMD) &&
                       wval[dcawd_pkg::CMD_SWRST_BIT];
    // R11 both supplies required
    assign sys_clear = !por_ok || soft_rst;
    assign load_rise = load_strobe && !load_q;
    assign osc_tick  = (osc_acc + OSC_STEP) >= SYS_MOD;
    // R15 R17 alarm aggregation
    assign fault_any = open_load || headroom_low || thermal ||
                       (wd_fault && watchdog_enable_bit) || (crc_flt && crcen);
    assign status    = 32'({held, clr_sync, headroom_low, open_load,
                            thermal, crc_flt, wd_fault});

    // R20 R22 period select
    always_comb begin
        unique case (tsel)
            2'h0: wd_limit = WD_LIM0;
            2'h1: wd_limit = WD_LIM1;
            2'h2: wd_limit = WD_LIM2;
            2'h3: wd_limit = WD_LIM3;
        endcase
    end

    always_comb begin
        next_clear_level_select_bit    = clear_level_select_bit;
        next_output_enable_bit     = output_enable_bit;
        next_bipolar   = bipolar;
        next_dual      = dual;
        next_watchdog_enable_bit      = watchdog_enable_bit;
        next_crcen     = crcen;
        next_tsel      = tsel;
        next_data      = data;
        next_pre_clear = pre_clear;
        next_held      = held;
        next_sclk_seen = sclk_seen;
        next_thermal   = thermal;
        next_crc_flt   = crc_flt;
        // R21 8 MHz tick from fractional divider
        next_osc_acc   = osc_tick ? 14'(osc_acc + OSC_STEP - SYS_MOD)
                                  : 14'(osc_acc + OSC_STEP);
        next_wait      = !((avs_read || avs_write) && avs_waitrequest);
        next_rdata     = avs_readdata;
        if ((avs_read || avs_write) && avs_waitrequest) begin
            unique case (avs_address)
                dcawd_pkg::ADDR_CTRL:   next_rdata = 32'({dual, bipolar,
                                                          output_enable_bit, clear_level_select_bit});
                dcawd_pkg::ADDR_CONFIG: next_rdata = 32'({crcen, tsel,
                                                          watchdog_enable_bit});
                dcawd_pkg::ADDR_DATA:   next_rdata = 32'(data);
                dcawd_pkg::ADDR_STATUS: next_rdata = status;
                default:                next_rdata = 32'h0000_0000;
            endcase
        end
        // R16 thermal hysteresis
        if (die_temp_c > dcawd_pkg::TEMP_SET_C) begin
            next_thermal = 1'b1;
        end else if (die_temp_c < dcawd_pkg::TEMP_CLR_C) begin
            next_thermal = 1'b0;
        end
        if (serial_clock_tick) begin
            next_sclk_seen = 1'b1;
        end
        if (load_rise) begin
            next_sclk_seen = 1'b0;
            // R6 restore on clockless load
            if (held && !clr_sync && !sclk_seen) begin
                next_data = pre_clear;
                next_held = 1'b0;
            end
        end
        if (wr_ok) begin
            unique case (avs_address)
                dcawd_pkg::ADDR_CTRL: begin
                    next_clear_level_select_bit  = wval[dcawd_pkg::CTRL_CLEAR_LEVEL_SELECT_BIT_BIT];
                    next_output_enable_bit   = wval[dcawd_pkg::CTRL_OUTPUT_ENABLE_BIT_BIT];
                    next_bipolar = wval[dcawd_pkg::CTRL_BIPOLAR_BIT];
                    next_dual    = wval[dcawd_pkg::CTRL_DUAL_BIT];
                    // R9 enable loads default
                    if (wval[dcawd_pkg::CTRL_OUTPUT_ENABLE_BIT_BIT] && !output_enable_bit &&
                        !clr_sync) begin
                        next_data = clr_code;
                        next_held = 1'b0;
                    end
                end
                dcawd_pkg::ADDR_CONFIG: begin
                    next_watchdog_enable_bit  = wval[dcawd_pkg::CFG_WATCHDOG_ENABLE_BIT_BIT];
                    next_tsel  = wval[dcawd_pkg::CFG_TSEL_LSB +: 2];
                    next_crcen = wval[dcawd_pkg::CFG_CRCEN_BIT];
                end
                dcawd_pkg::ADDR_DATA: begin
                    // R7 writes rejected during clear
                    if (!clr_sync) begin
                        next_data = wval[15:0];
                        next_held = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // R1 R5 clear forces and holds value
        if (clr_sync) begin
            if (!held) begin
                next_pre_clear = data;
            end
            next_data = clr_code;
            next_held = 1'b1;
        end
        if (!crcen) begin
            next_crc_flt = 1'b0;
        end
        // The sys_clear branch below wins over a set of the frame fault.
        if (frame_check_error && crcen) begin
            next_crc_flt = 1'b1;
        end
        // R12 defaults, data from select pin
        if (sys_clear) begin
            next_clear_level_select_bit    = 1'b0;
            next_output_enable_bit     = 1'b0;
            next_bipolar   = 1'b0;
            next_dual      = 1'b0;
            next_watchdog_enable_bit      = 1'b0;
            next_crcen     = 1'b0;
            next_tsel      = 2'h0;
            next_data      = clear_level_select_pin ? dcawd_pkg::CODE_MID
                                                    : dcawd_pkg::CODE_ZERO;
            next_pre_clear = next_data;
            next_held      = 1'b0;
            next_crc_flt   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clear_level_select_bit          <= 1'b0;
            output_enable_bit           <= 1'b0;
            bipolar         <= 1'b0;
            dual            <= 1'b0;
            watchdog_enable_bit            <= 1'b0;
            crcen           <= 1'b0;
            tsel            <= 2'h0;
            data            <= 16'h0000;
            pre_clear       <= 16'h0000;
            held            <= 1'b0;
            sclk_seen       <= 1'b0;
            load_q          <= 1'b0;
            por_ok          <= 1'b0;
            thermal         <= 1'b0;
            crc_flt         <= 1'b0;
            osc_acc         <= 14'h0000;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            voltage_code    <= 16'h0000;
            current_code    <= 16'h0000;
            output_active   <= 1'b0;
            fault_out       <= 1'b0;
            fault_oe_n      <= 1'b1;
        end else begin
            clear_level_select_bit          <= next_clear_level_select_bit;
            output_enable_bit           <= next_output_enable_bit;
            bipolar         <= next_bipolar;
            dual            <= next_dual;
            watchdog_enable_bit            <= next_watchdog_enable_bit;
            crcen           <= next_crcen;
            tsel            <= next_tsel;
            data            <= next_data;
            pre_clear       <= next_pre_clear;
            held            <= next_held;
            sclk_seen       <= next_sclk_seen;
            load_q          <= load_strobe;
            por_ok          <= digital_supply_ok && analog_supply_ok;
            thermal         <= next_thermal;
            crc_flt         <= next_crc_flt;
            osc_acc         <= next_osc_acc;
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_rdata;
            voltage_code    <= next_data;
            // R4 current output at range bottom
            current_code    <= next_held ? dcawd_pkg::CODE_ZERO : next_data;
            output_active   <= next_output_enable_bit;
            fault_out       <= 1'b0;
            // R15 drive fault pin low
            fault_oe_n      <= !fault_any;
        end
    end

    // R23 qualifying host frame restarts watchdog
    dcawd_watchdog #(
        .CNT_W (24)
    ) u_watchdog (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .osc_tick   (osc_tick),
        .enable     (watchdog_enable_bit),
        .tsel       (tsel),
        .kick       (frame_valid && (frame_addr == dcawd_pkg::WD_KICK_ADDR)),
        .soft_clear (sys_clear),
        .limit      (wd_limit),
        .fault      (wd_fault)
    );

    // ***********************************************************
    // Checks
    // ***********************************************************
    a_fault_pin_drive: assert property ( // R15
        @(posedge clk_sys) disable iff (!rst_n)
        (open_load || thermal) |=> !fault_oe_n)
        else $error("fault pin not driven on alarm");

    a_fault_wd_gated: assert property ( // R17
        @(posedge clk_sys) disable iff (!rst_n)
        (!watchdog_enable_bit && !crcen && !open_load && !headroom_low && !thermal)
            |=> fault_oe_n)
        else $error("disabled fault source reached pin");

    a_clear_data_code: assert property ( // R3
        @(posedge clk_sys) disable iff (!rst_n)
        (clr_sync && !sys_clear) |=> data == $past(clr_code))
        else $error("clear code wrong");

    a_current_low: assert property ( // R4
        @(posedge clk_sys) disable iff (!rst_n)
        held |-> current_code == dcawd_pkg::CODE_ZERO)
        else $error("current not at range bottom during clear");

    a_write_blocked: assert property ( // R7
        @(posedge clk_sys) disable iff (!rst_n)
        (clr_sync && held && !sys_clear) |=> $stable(data))
        else $error("data changed while clear held");

    a_restore_value: assert property ( // R6
        @(posedge clk_sys) disable iff (!rst_n)
        (load_rise && held && !clr_sync && !sclk_seen && !sys_clear)
            |=> (data == $past(pre_clear)) && !held)
        else $error("pre-clear value not restored");

    a_output_enable_bit_default: assert property ( // R9
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_ok && avs_address == dcawd_pkg::ADDR_CTRL && !output_enable_bit &&
         wval[dcawd_pkg::CTRL_OUTPUT_ENABLE_BIT_BIT] && !clr_sync && !sys_clear)
            |=> data == $past(clr_code))
        else $error("enable did not load default value");

    a_thermal_hold: assert property ( // R16
        @(posedge clk_sys) disable iff (!rst_n)
        (thermal && die_temp_c >= dcawd_pkg::TEMP_CLR_C) |=> thermal)
        else $error("thermal alarm released above lower threshold");

    a_bus_answer: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");

endmodule : dcawd_ctrl
`default_nettype wire

// >>> logic/dcawd_pkg.sv
// Constants shared by the converter clear, alarm and watchdog control logic.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register port.
package dcawd_pkg;

    // ***********************************************************
    // Register map (byte addresses)
    // ***********************************************************
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_CONFIG = 5'h04;
    localparam logic [4:0] ADDR_DATA   = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0C;
    localparam logic [4:0] ADDR_CMD    = 5'h10;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int CTRL_CLEAR_LEVEL_SELECT_BIT_BIT  = 0;
    localparam int CTRL_OUTPUT_ENABLE_BIT_BIT   = 1;
    localparam int CTRL_BIPOLAR_BIT = 2;
    localparam int CTRL_DUAL_BIT    = 3;
    localparam int CFG_WATCHDOG_ENABLE_BIT_BIT     = 0;
    localparam int CFG_TSEL_LSB     = 1;
    localparam int CFG_CRCEN_BIT    = 3;
    localparam int CMD_SWRST_BIT    = 0;
    localparam int ST_WDFLT_BIT     = 0;
    localparam int ST_CRCFLT_BIT    = 1;
    localparam int ST_THERM_BIT     = 2;
    localparam int ST_OPEN_BIT      = 3;
    localparam int ST_HEAD_BIT      = 4;
    localparam int ST_CLRIN_BIT     = 5;
    localparam int ST_HELD_BIT      = 6;

    // ***********************************************************
    // Codes, thresholds and timing
    // ***********************************************************
    localparam logic [15:0] CODE_ZERO     = 16'h0000;
    localparam logic [15:0] CODE_MID      = 16'h8000;
    localparam logic [7:0]  WD_KICK_ADDR  = 8'h95;
    localparam logic signed [9:0] TEMP_SET_C = 10'sd142;
    localparam logic signed [9:0] TEMP_CLR_C = 10'sd124;
    localparam int SYS_KHZ = 10000;
    localparam int OSC_KHZ = 8000;

endpackage : dcawd_pkg

// >>> logic/dcawd_watchdog.sv
// Serial watchdog: counts oscillator ticks and flags a missing host frame.
// Assumes osc_tick is a one-cycle enable and all inputs are synchronous.
`timescale 1ns/10ps
`default_nettype none
module dcawd_watchdog #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Control
    input  wire logic             osc_tick,
    input  wire logic             enable,
    input  wire logic [1:0]       tsel,
    input  wire logic             kick,
    input  wire logic             soft_clear,
    input  wire logic [CNT_W-1:0] limit,
    // Result
    output logic                  fault
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_fault;
    logic             en_q;
    logic [1:0]       tsel_q;
    logic             restart;

    always_comb begin
        // R25 restart conditions
        restart    = kick || (enable && !en_q) || (tsel != tsel_q);
        next_count = count;
        next_fault = fault;
        // R19 runs only when enabled
        if (!enable || restart) begin
            next_count = '0;
        end else if (osc_tick) begin
            // R21 counts oscillator ticks
            next_count = count + 1'b1;
        end
        // R24 flag clear paths
        if (!enable || soft_clear) begin
            next_fault = 1'b0;
        end
        // R22 period reached
        if (enable && !restart && osc_tick && (count + 1'b1 >= limit)) begin
            next_fault = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count  <= '0;
            fault  <= 1'b0;
            en_q   <= 1'b0;
            tsel_q <= 2'h0;
        end else begin
            count  <= next_count;
            fault  <= next_fault;
            en_q   <= enable;
            tsel_q <= tsel;
        end
    end

    // ***********************************************************
    // Checks
    // ***********************************************************
    a_wd_disabled: assert property ( // R19
        @(posedge clk_sys) disable iff (!rst_n)
        !enable |=> (count == '0) && !fault)
        else $error("watchdog active while disabled");

    a_wd_kick_zero: assert property ( // R25
        @(posedge clk_sys) disable iff (!rst_n)
        kick |=> count == '0)
        else $error("watchdog count not restarted by frame");

    a_wd_flag_clear: assert property ( // R24
        @(posedge clk_sys) disable iff (!rst_n)
        (soft_clear && !(enable && osc_tick)) |=> !fault)
        else $error("watchdog flag survived software reset");

endmodule : dcawd_watchdog
`default_nettype wire

// >>> verif/dcawd_host_model.sv
// Host model: serial frames that kick the watchdog every 2000 cycles.
// Assumes clk_sys at 10 MHz; kick_en gates the frames.
`timescale 1ns/10ps
`default_nettype none
module dcawd_host_model (
    // Clock and control
    input  wire logic  clk_sys,
    input  wire logic  kick_en,
    // Serial frame side
    output logic       frame_valid,
    output logic [7:0] frame_addr,
    output logic       serial_clock_tick
);
    int n = 0;
    initial begin
        frame_valid = 1'b0;
        frame_addr = 8'h00;
        serial_clock_tick = 1'b0;
    end
    always @(posedge clk_sys) begin
        n <= (n == 1999) ? 0 : n + 1;
        serial_clock_tick <= kick_en && (n < 24);
        frame_valid <= kick_en && (n == 24);
        // The address lines invert every cycle outside frames, so 0x95 recurs every other cycle after a frame.
        frame_addr <= (kick_en && n == 24) ? dcawd_pkg::WD_KICK_ADDR
                                           : ~frame_addr;
    end
endmodule : dcawd_host_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the clear, alarm and watchdog control block.
// Assumes WD_MS0 of 1 ms so a timeout takes 10000 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys = 0, rstn = 0, avs_read = 0, avs_write = 0, load_strobe = 0;
    logic [4:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic avs_waitrequest, clear_forced, output_active, fault_oe_n, kick_en = 0;
    logic output_clear_input = 0, clear_level_select_pin = 0, open_load = 0;
    logic analog_supply_ok = 1, digital_supply_ok = 1, headroom_low = 0;
    logic frame_valid, serial_clock_tick, fault_out;
    logic [7:0] frame_addr;
    logic signed [9:0] die_temp_c = 10'sd25;
    logic [15:0] current_code, voltage_code, v, e;
    logic [31:0] c;
    logic [63:0] q[$];
    int err_total = 0, checks_done = 0;
    always #50 clk_sys = ~clk_sys;
    dcawd_ctrl #(.WD_MS0(1)) u_dut (.clk_sys, .rstn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .output_clear_input, .clear_level_select_pin,
        .load_strobe, .serial_clock_tick, .frame_valid, .frame_addr,
        .frame_check_error(1'b0), .digital_supply_ok, .analog_supply_ok,
        .open_load, .headroom_low, .die_temp_c, .clear_forced,
        .voltage_code, .current_code, .output_active, .fault_out,
        .fault_oe_n);
    dcawd_host_model u_host (.clk_sys, .kick_en, .frame_valid, .frame_addr,
        .serial_clock_tick);
    task automatic give_verdict;
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [31:0] x,
                      input logic [31:0] m);
        q.push_back({m, x});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_pin(input int n, input logic x);
        repeat (n) @(posedge clk_sys);
        #1 cmp({fault_out, fault_oe_n}, {1'b0, x});
    endtask : wait_pin
    // Read results are compared in the cycle they stand.
    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            cmp(avs_readdata & q[0][63:32], q[0][31:0]);
            void'(q.pop_front());
        end
    end
    initial begin
        #6ms err_total++;
        give_verdict();
    end
    initial begin
        void'($urandom(11264));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(dcawd_pkg::ADDR_DATA, 32'h0, 32'hFFFF);
        for (int i = 0; i < 4; i++) begin
            c = {28'h0, i[1], i[0], 2'b00};
            c[0] = (i == 2);
            clear_level_select_pin <= (i == 3);
            bus(1'b1, dcawd_pkg::ADDR_CTRL, c);
            e = ((c[0] | (i == 3)) ^ c[2]) ? dcawd_pkg::CODE_MID
                                           : dcawd_pkg::CODE_ZERO;
            v = 16'($urandom);
            bus(1'b1, dcawd_pkg::ADDR_DATA, {16'h0, v});
            @(posedge clk_sys);
            output_clear_input <= 1'b1;
            #1 cmp(clear_forced, 1'b1);
            bus(1'b1, dcawd_pkg::ADDR_DATA, {16'h0, ~v});
            rd(dcawd_pkg::ADDR_DATA, e, 32'hFFFF);
            #1 cmp(current_code, 16'h0);
            cmp(voltage_code, e);
            output_clear_input <= 1'b0;
            repeat (4) @(posedge clk_sys);
            rd(dcawd_pkg::ADDR_DATA, e, 32'hFFFF);
            load_strobe <= 1'b1;
            repeat (2) @(posedge clk_sys);
            load_strobe <= 1'b0;
            repeat (3) @(posedge clk_sys);
            rd(dcawd_pkg::ADDR_DATA, v, 32'hFFFF);
        end
        bus(1'b1, dcawd_pkg::ADDR_CTRL, 32'h0);
        bus(1'b1, dcawd_pkg::ADDR_CTRL, 32'h2);
        rd(dcawd_pkg::ADDR_DATA, dcawd_pkg::CODE_MID, 32'hFFFF);
        #1 cmp(output_active, 1'b1);
        analog_supply_ok <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clear_level_select_pin <= 1'b0;
        analog_supply_ok <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(dcawd_pkg::ADDR_DATA, 32'h0, 32'hFFFF);
        bus(1'b1, dcawd_pkg::ADDR_DATA, 32'h1234);
        digital_supply_ok <= 1'b0;
        repeat (3) @(posedge clk_sys);
        digital_supply_ok <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(dcawd_pkg::ADDR_DATA, 32'h0, 32'hFFFF);
        bus(1'b1, dcawd_pkg::ADDR_DATA, 32'h1234);
        load_strobe <= 1'b1;
        @(posedge clk_sys);
        load_strobe <= 1'b0;
        bus(1'b1, dcawd_pkg::ADDR_CMD, 32'h1);
        rd(dcawd_pkg::ADDR_DATA, 32'h0, 32'hFFFF);
        die_temp_c <= 10'sd143;
        wait_pin(4, 1'b0);
        die_temp_c <= 10'sd130;
        wait_pin(4, 1'b0);
        rd(dcawd_pkg::ADDR_STATUS, 32'h4, 32'h4);
        die_temp_c <= 10'sd123;
        wait_pin(4, 1'b1);
        open_load <= 1'b1;
        wait_pin(4, 1'b0);
        open_load <= 1'b0;
        headroom_low <= 1'b1;
        wait_pin(4, 1'b0);
        headroom_low <= 1'b0;
        wait_pin(12000, 1'b1);
        kick_en <= 1'b1;
        bus(1'b1, dcawd_pkg::ADDR_CONFIG, 32'h1);
        wait_pin(15000, 1'b1);
        do @(posedge clk_sys); while (frame_valid !== 1'b1);
        kick_en <= 1'b0;
        wait_pin(9500, 1'b1);
        wait_pin(1500, 1'b0);
        rd(dcawd_pkg::ADDR_STATUS, 32'h1, 32'h1);
        bus(1'b1, dcawd_pkg::ADDR_CONFIG, 32'h0);
        rd(dcawd_pkg::ADDR_STATUS, 32'h0, 32'h1);
        wait_pin(2, 1'b1);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
